/* smb_err_slave.sv */
// slave-side bus engine with error signalling and timeout supervision
// assumes open-drain pads outside and user logic on CLK_SYS
`timescale 1ns/100ps

module smb_err_slave import smb_err_pkg::*; #(
	parameter int unsigned TOUT_CYC = `TOUT_CYC,
	parameter int unsigned SEXT_CYC = `SEXT_CYC,
	parameter int unsigned IDLE_CYC = `IDLE_CYC
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RST_N, // async reset
	input wire logic SCL_I, // clock pad level
	input wire logic SDA_I, // data pad level
	output logic SCL_O, // clock drive value
	output logic SCL_OE, // clock pulled low
	output logic SDA_O, // data drive value
	output logic SDA_OE, // data pulled low
	input wire logic [6:0] SLV_ADDR, // own address
	input wire logic PEC_EN, // check bytes in use
	input wire logic PEC_LAST, // next rx byte is check byte
	input wire cause_t ERR_IN, // user error causes
	input wire logic HOLD_REQ, // stretch clock
	input wire logic FORCE_TOUT, // force clock-low timeout
	input wire logic [7:0] TX_DATA, // byte to send
	input wire logic ERR_CLR, // clear error flag
	output rx_t RX, // received byte
	output logic RX_VALID, // rx byte pulse
	output logic TX_LOAD, // tx byte taken pulse
	output logic [7:0] PEC_VAL, // running check value
	output err_t ERR_FLAG, // sticky errors
	output logic XFER_ERR, // nack pulse
	output logic TIMEOUT, // timeout pulse
	output logic MSG_DONE, // stop seen pulse
	output logic BUS_IDLE, // idle bus
	output logic BUSY // engine active
);

	localparam cnt_t TOUT_LIM = cnt_t'(TOUT_CYC);
	localparam cnt_t SEXT_LIM = cnt_t'(SEXT_CYC);
	localparam cnt_t IDLE_LIM = cnt_t'(IDLE_CYC);

	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8

	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	state_t state_q;
	logic [7:0] sh_q;
	logic [2:0] cnt_q;
	logic done_q, addr_ph_q, first_q, rw_q, nack_q, load_q;
	cnt_t low_cnt_q, hi_cnt_q, stretch_q;
	logic scl_rise, scl_fall, start_det, stop_det, addr_hit;
	logic pec_bad, byte_bad, dec, tout_hit, over_hit, abort, hold_ok;
	logic [7:0] crc_rx, crc_tx;
	err_t err_new;

	// two-stage sync of the pads
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= SCL_I;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= SDA_I;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	assign scl_rise = scl_s_q && !scl_p_q;
	assign scl_fall = !scl_s_q && scl_p_q;
	assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign addr_hit = sh_q[7:1] == SLV_ADDR;
	assign crc_rx = crc8(PEC_VAL, sh_q);
	assign crc_tx = crc8(PEC_VAL, TX_DATA);
	assign pec_bad = PEC_EN && PEC_LAST && (crc_rx != 8'h00);
	assign byte_bad = (|ERR_IN) || pec_bad;
	// timeout once low beyond the least limit
	assign tout_hit = !scl_s_q && (low_cnt_q == TOUT_LIM - cnt_t'(1));
	assign over_hit = SCL_OE && (state_q != ST_HOLD)
		&& (stretch_q == SEXT_LIM - cnt_t'(1));
	assign abort = tout_hit || over_hit;
	assign dec = (state_q == ST_RX) && scl_fall && done_q && !addr_ph_q
		&& !abort;
	assign hold_ok = state_q inside {ST_RX, ST_ACK, ST_TX, ST_MACK};

	always_comb begin
		err_new = '0;
		if (dec) begin
			err_new.cause = ERR_IN;
			err_new.bad_pec = pec_bad;
		end
		err_new.tout = tout_hit;
		err_new.overstretch = over_hit;
	end

	// protocol engine
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 3'h0;
			done_q <= 1'b0;
			addr_ph_q <= 1'b0;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			load_q <= 1'b0;
			PEC_VAL <= `CRC_INIT;
			SDA_OE <= 1'b0;
			RX <= '0;
			RX_VALID <= 1'b0;
			TX_LOAD <= 1'b0;
			XFER_ERR <= 1'b0;
			MSG_DONE <= 1'b0;
		end else begin
			RX_VALID <= 1'b0;
			TX_LOAD <= 1'b0;
			XFER_ERR <= 1'b0;
			MSG_DONE <= 1'b0;
			if (abort) begin
				// drop partial byte, release, wait for start
				state_q <= ST_IDLE;
				SDA_OE <= 1'b0;
				done_q <= 1'b0;
				cnt_q <= 3'h0;
				load_q <= 1'b0;
			end else if (stop_det) begin
				MSG_DONE <= state_q != ST_IDLE;
				state_q <= ST_IDLE;
				SDA_OE <= 1'b0;
			end else if (start_det) begin
				state_q <= ST_RX;
				addr_ph_q <= 1'b1;
				cnt_q <= 3'h0;
				done_q <= 1'b0;
				load_q <= 1'b0;
				PEC_VAL <= `CRC_INIT;
				SDA_OE <= 1'b0;
			end else begin
				case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s_q};
						cnt_q <= cnt_q + 3'h1;
						done_q <= cnt_q == `BIT_LAST;
					end else if (scl_fall && done_q) begin
						done_q <= 1'b0;
						PEC_VAL <= crc_rx;
						if (addr_ph_q) begin
							addr_ph_q <= 1'b0;
							first_q <= 1'b1;
							rw_q <= sh_q[0];
							nack_q <= 1'b0;
							SDA_OE <= addr_hit;
							state_q <= addr_hit ? ST_ACK : ST_WAIT;
						end else begin
							nack_q <= byte_bad;
							SDA_OE <= !byte_bad;
							XFER_ERR <= byte_bad;
							RX_VALID <= !byte_bad;
							RX <= '{first: first_q, data: sh_q};
							first_q <= 1'b0;
							state_q <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						SDA_OE <= 1'b0;
						cnt_q <= 3'h0;
						// nothing more is taken after an error
						if (nack_q) begin
							state_q <= ST_WAIT;
						end else if (rw_q) begin
							state_q <= ST_TX;
							load_q <= 1'b1;
						end else begin
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (load_q) begin
						if (!HOLD_REQ && !scl_s_q) begin
							sh_q <= TX_DATA;
							SDA_OE <= !TX_DATA[7];
							PEC_VAL <= crc_tx;
							TX_LOAD <= 1'b1;
							load_q <= 1'b0;
						end
					end else if (FORCE_TOUT && !scl_s_q) begin
						// hold clock low to force a timeout
						state_q <= ST_HOLD;
						SDA_OE <= 1'b0;
					end else if (scl_rise) begin
						cnt_q <= cnt_q + 3'h1;
						done_q <= cnt_q == `BIT_LAST;
					end else if (scl_fall) begin
						if (done_q) begin
							done_q <= 1'b0;
							SDA_OE <= 1'b0;
							state_q <= ST_MACK;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							SDA_OE <= !sh_q[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						cnt_q <= 3'h0;
						// master nack ends the read quietly
						if (!sda_s_q) begin
							state_q <= ST_TX;
							load_q <= 1'b1;
						end else begin
							state_q <= ST_WAIT;
						end
					end
				end
				ST_HOLD, ST_WAIT, ST_IDLE: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// clock stretch and forced hold
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SCL_OE <= 1'b0;
			stretch_q <= '0;
		end else begin
			SCL_OE <= !abort && ((state_q == ST_HOLD)
				|| (HOLD_REQ && hold_ok && !scl_s_q));
			// stretch summed from start to stop
			if (start_det || state_q == ST_IDLE) begin
				stretch_q <= '0;
			end else if (SCL_OE && state_q != ST_HOLD) begin
				stretch_q <= stretch_q + cnt_t'(1);
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_q <= '0;
			hi_cnt_q <= '0;
			TIMEOUT <= 1'b0;
			BUS_IDLE <= 1'b0;
		end else begin
			TIMEOUT <= tout_hit;
			// a stopped high clock never counts
			if (scl_s_q) begin
				low_cnt_q <= '0;
			end else if (low_cnt_q != TOUT_LIM) begin
				low_cnt_q <= low_cnt_q + cnt_t'(1);
			end
			// idle after both lines high long enough
			if (!(scl_s_q && sda_s_q)) begin
				hi_cnt_q <= '0;
				BUS_IDLE <= 1'b0;
			end else if (hi_cnt_q != IDLE_LIM) begin
				hi_cnt_q <= hi_cnt_q + cnt_t'(1);
				BUS_IDLE <= hi_cnt_q == IDLE_LIM - cnt_t'(1);
			end
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ERR_FLAG <= '0;
			BUSY <= 1'b0;
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
		end else begin
			ERR_FLAG <= err_t'((ERR_CLR ? '0 : ERR_FLAG) | err_new);
			BUSY <= state_q != ST_IDLE;
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	tout_release_a: assert property (
		tout_hit |=> state_q == ST_IDLE && !SDA_OE && !SCL_OE && TIMEOUT)
		else $error("timeout did not release the bus");
	tout_count_a: assert property (
		TIMEOUT |-> $past(low_cnt_q) == TOUT_LIM - cnt_t'(1)
		&& $past(!scl_s_q))
		else $error("timeout at wrong low count");
	stretch_cap_a: assert property (
		over_hit |=> !SCL_OE && state_q == ST_IDLE && ERR_FLAG.overstretch)
		else $error("overstretch not handled");
	idle_flag_a: assert property (
		BUS_IDLE |-> $past(hi_cnt_q) >= IDLE_LIM - cnt_t'(1)
		&& $past(scl_s_q && sda_s_q))
		else $error("idle flag without full high time");
	mack_quiet_a: assert property (
		(state_q == ST_MACK && scl_rise && sda_s_q && !abort && !stop_det
		&& !start_det) |=> state_q == ST_WAIT && !XFER_ERR && !SDA_OE)
		else $error("read end taken as error");
	nack_byte_a: assert property (
		(dec && byte_bad && !stop_det && !start_det)
		|=> XFER_ERR && !RX_VALID && !SDA_OE ##1 !XFER_ERR)
		else $error("bad byte acknowledged");
	ack_byte_a: assert property (
		(dec && !byte_bad && !stop_det && !start_det)
		|=> SDA_OE && RX_VALID && !XFER_ERR)
		else $error("good byte not acknowledged");
	stop_idle_a: assert property (
		(stop_det && !abort) |=> state_q == ST_IDLE && !SDA_OE)
		else $error("stop did not end transfer");
	err_hold_a: assert property (
		(ERR_FLAG.bad_pec && !ERR_CLR) |=> ERR_FLAG.bad_pec)
		else $error("error flag lost");
	start_seen_a: assert property (
		(start_det && !abort) |=> state_q == ST_RX && PEC_VAL == 8'h00)
		else $error("start not taken");

endmodule : smb_err_slave

/* smb_err_consts.svh */
// constants for the bus error and timeout supervisor
// included by the package; no module of its own
`ifndef SMB_ERR_CONSTS_SVH
`define SMB_ERR_CONSTS_SVH

// local clock rate
`define CLK_MHZ 200
// clock-low timeout, least and longest, in us
`define TOUT_MIN_US 25000
`define TOUT_MAX_US 35000
// cumulative slave stretch limit, in us
`define SEXT_MAX_US 25000
// longest clock-high period, in us
`define THIGH_MAX_US 50
// cycle counts derived from the rate
`define TOUT_CYC (`TOUT_MIN_US * `CLK_MHZ)
`define SEXT_CYC (`SEXT_MAX_US * `CLK_MHZ)
`define IDLE_CYC (`THIGH_MAX_US * `CLK_MHZ)
`define CNT_W 24
`define CRC_INIT 8'h00
`define CRC_POLY 8'h07
`define BIT_LAST 3'h7

`endif

/* smb_err_pkg.sv */
// types shared by the bus error and timeout supervisor
// relies on the constants header
package smb_err_pkg;
`include "smb_err_consts.svh"

	typedef logic [`CNT_W-1:0] cnt_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RX = 7'h02,
		ST_ACK = 7'h04,
		ST_TX = 7'h08,
		ST_MACK = 7'h10,
		ST_HOLD = 7'h20,
		ST_WAIT = 7'h40
	} state_t;

	typedef struct packed {
		logic not_ready;
		logic bad_cmd;
		logic forbidden;
		logic ovf_unf;
		logic bad_size;
		logic bad_proto;
	} cause_t;

	typedef struct packed {
		cause_t cause;
		logic bad_pec;
		logic tout;
		logic overstretch;
	} err_t;

	typedef struct packed {
		logic first;
		logic [7:0] data;
	} rx_t;

endpackage : smb_err_pkg

/* smb_master_model.sv */
// partner model: bus master on the wired clock and data lines
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/100ps
module smb_master_model (
	input wire logic scl, // clock line
	input wire logic sda, // data line
	output logic scl_low, // pulls clock low
	output logic sda_low // pulls data low
);
	// bench link runs fast; master adds no stretch of its own
	localparam int HALF = 40;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// releases clock, waits out a stretch
	task automatic rise();
		int n;
		n = 0;
		scl_low = 1'b0;
		while (scl !== 1'b1 && n < 4000) begin
			#5;
			n++;
		end
		#HALF;
	endtask : rise
	task automatic start();
		sda_low = 1'b0;
		scl_low = 1'b0;
		#HALF;
		sda_low = 1'b1;
		#HALF;
		scl_low = 1'b1;
	endtask : start
	task automatic stop();
		#10;
		sda_low = 1'b1;
		#(HALF - 10);
		rise();
		sda_low = 1'b0;
		#HALF;
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		logic [8:0] v;
		logic [8:0] o;
		v = {d, ai};
		for (int i = 8; i >= 0; i--) begin
			#10;
			sda_low = !v[i];
			#(HALF - 10);
			rise();
			o[i] = sda;
			scl_low = 1'b1;
		end
		q = o[8:1];
		ao = o[0];
	endtask : xfer
endmodule : smb_master_model

/* smbus_timeout_error_handler_tb.sv */
// bench for the slave error, abort and timeout supervisor
// assumes package, design and master model compiled first
`timescale 1ns/100ps
module smbus_timeout_error_handler_tb import smb_err_pkg::*;;
	localparam int TOUT = 400;
	localparam int SEXT = 300;
	localparam int IDLE = 50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pec_en = 1'b0;
	logic pec_last = 1'b0;
	logic hold = 1'b0;
	logic force_to = 1'b0;
	logic err_clr = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [6:0] addr = 7'h3A;
	cause_t err_in = '0;
	logic scl_oe, sda_oe, m_scl, m_sda, busy, idle, rx_v, xerr, tout, done;
	logic [7:0] pec_val, q;
	logic scl_o, sda_o, tx_ld;
	int n_tl = 0;
	logic a;
	err_t flag;
	rx_t rx, rx_last;
	logic [31:0] rnd = 32'h21449C31;
	int n_rx = 0, n_xe = 0, n_to = 0, n_md = 0;
	int failures = 0;
	int comparisons = 0;
	// wired lines with pull-ups
	wire scl = !(scl_oe || m_scl);
	wire sda = !(sda_oe || m_sda);
	smb_err_slave #(.TOUT_CYC(TOUT), .SEXT_CYC(SEXT), .IDLE_CYC(IDLE)) dut (
		.CLK_SYS(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda),
		.SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.SLV_ADDR(addr),
		.PEC_EN(pec_en), .PEC_LAST(pec_last), .ERR_IN(err_in),
		.HOLD_REQ(hold), .FORCE_TOUT(force_to), .TX_DATA(tx_data),
		.ERR_CLR(err_clr), .RX(rx), .RX_VALID(rx_v), .TX_LOAD(tx_ld),
		.PEC_VAL(pec_val), .ERR_FLAG(flag), .XFER_ERR(xerr),
		.TIMEOUT(tout), .MSG_DONE(done), .BUS_IDLE(idle), .BUSY(busy));
	smb_master_model mdl (.scl(scl), .sda(sda), .scl_low(m_scl),
		.sda_low(m_sda));
	always #2.5 clk = !clk;
	// pulse counters
	always @(posedge clk) begin
		if (rx_v === 1'b1) begin
			n_rx <= n_rx + 1;
			rx_last <= rx;
		end
		if (xerr === 1'b1) n_xe <= n_xe + 1;
		if (tx_ld === 1'b1) n_tl <= n_tl + 1;
		if (tout === 1'b1) n_to <= n_to + 1;
		if (done === 1'b1) n_md <= n_md + 1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] crc8(input logic [7:0] c, d);
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chk_v(input string s, input logic [8:0] e, g);
		#1;
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk_v
	task automatic chk_b(input string s, input logic e, g);
		chk_v(s, {8'h00, e}, {8'h00, g});
	endtask : chk_b
	task automatic clr();
		@(posedge clk) err_clr <= 1'b1;
		@(posedge clk) err_clr <= 1'b0;
		@(posedge clk);
		chk_v("flag cleared", 9'h000, flag);
	endtask : clr
	task automatic begin_msg(input logic rd);
		mdl.start();
		mdl.xfer({addr, rd}, 1'b1, q, a);
		chk_b("address ack", 1'b0, a);
	endtask : begin_msg
	task automatic wait_to(input int base, output int cyc);
		cyc = 0;
		while (n_to == base && cyc < 2000) begin
			@(posedge clk);
			cyc++;
		end
	endtask : wait_to
	initial begin
		#400000;
		failures++;
		stop_test();
	end
	initial begin
		logic [7:0] d, d2, p;
		cause_t c;
		int b, e, cyc;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i <= 6; i++) begin
			c = (i < 6) ? cause_t'(6'h20 >> i) : cause_t'(6'h00);
			d = rnd[7:0];
			d2 = rnd[15:8];
			rnd = lfsr(rnd);
			b = n_rx;
			e = n_xe;
			begin_msg(1'b0);
			@(posedge clk) err_in <= c;
			mdl.xfer(d, 1'b1, q, a);
			chk_b("data ack", c != 0, a);
			@(posedge clk) err_in <= '0;
			mdl.xfer(d2, 1'b1, q, a);
			chk_b("ignored after error", c != 0, a);
			chk_v("rx count", (c != 0) ? 9'd0 : 9'd2, 9'(n_rx - b));
			chk_v("nack pulses", (c != 0) ? 9'd1 : 9'd0, 9'(n_xe - e));
			chk_v("error flag", {c, 3'b000}, flag);
			p = crc8(crc8(crc8(8'h00, {addr, 1'b0}), d), d2);
			if (c == 0) begin
				chk_v("rx byte", {1'b0, d2}, rx_last);
				chk_v("check value", {1'b0, p}, {1'b0, pec_val});
			end
			mdl.stop();
			clr();
		end
		$display("test error causes done");
		@(posedge clk) pec_en <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			d = rnd[7:0];
			rnd = lfsr(rnd);
			p = crc8(crc8(8'h00, {addr, 1'b0}), d) ^ (k == 0 ? 8'h5A : 8'h00);
			begin_msg(1'b0);
			mdl.xfer(d, 1'b1, q, a);
			@(posedge clk) pec_last <= 1'b1;
			mdl.xfer(p, 1'b1, q, a);
			@(posedge clk) pec_last <= 1'b0;
			chk_b("check byte ack", k == 0, a);
			chk_v("check flag", (k == 0) ? 9'h004 : 9'h000, flag);
			mdl.stop();
			clr();
		end
		$display("test check byte done");
		@(posedge clk) pec_en <= 1'b0;
		tx_data <= rnd[7:0];
		b = n_md;
		e = n_tl;
		begin_msg(1'b1);
		mdl.xfer(8'hFF, 1'b0, q, a);
		chk_v("read byte", {1'b0, tx_data}, {1'b0, q});
		mdl.xfer(8'hFF, 1'b1, q, a);
		chk_v("read byte", {1'b0, tx_data}, {1'b0, q});
		mdl.stop();
		chk_v("final nack", 9'h000, flag);
		chk_v("stop seen", 9'd1, 9'(n_md - b));
		chk_v("tx loads", 9'd2, 9'(n_tl - e));
		chk_v("drive values", 9'd0, {7'd0, scl_o, sda_o});
		chk_b("idle early", 1'b0, idle);
		b = n_to;
		repeat (IDLE + 6) @(posedge clk);
		chk_b("idle", 1'b1, idle);
		repeat (2 * TOUT) @(posedge clk);
		chk_v("idle clock stop", 9'd0, 9'(n_to - b));
		$display("test read and idle done");
		begin_msg(1'b0);
		wait_to(n_to, cyc);
		chk_b("timeout time", 1'b1, cyc >= TOUT - 4 && cyc <= TOUT + 12);
		chk_v("timeout flag", 9'h002, flag);
		chk_b("released", 1'b0, sda_oe | scl_oe | busy);
		mdl.stop();
		clr();
		@(posedge clk) force_to <= 1'b1;
		begin_msg(1'b1);
		repeat (10) @(posedge clk);
		mdl.scl_low = 1'b0;
		wait_to(n_to, cyc);
		chk_b("forced hold", 1'b1, cyc >= TOUT - 24 && cyc <= TOUT + 12);
		@(posedge clk) force_to <= 1'b0;
		repeat (4) @(posedge clk);
		chk_b("lines high", 1'b1, scl & sda);
		clr();
		$display("test timeouts done");
		@(posedge clk) hold <= 1'b1;
		mdl.start();
		mdl.xfer({addr, 1'b0}, 1'b1, q, a);
		chk_v("overstretch flag", 9'h001, flag);
		mdl.stop();
		@(posedge clk) hold <= 1'b0;
		clr();
		$display("test stretch done");
		stop_test();
	end
endmodule : smbus_timeout_error_handler_tb
